// [hw/lcdsc_pump_div.sv]
// Charge pump clock divider: system clock / 16 / (field + 1)
`timescale 1ns/1ns
module lcdsc_pump_div
   import lcdsc_pkg::*;
#(
   parameter int DIV_W = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [DIV_W-1:0] div_val,
   input wire logic reload,
   input wire logic run,
   output logic pump_clk
);
   typedef struct packed {
      logic [3:0] pre;
      logic [DIV_W-1:0] cnt;
      logic out;
   } lcdsc_div_state_type;
   lcdsc_div_state_type st_ff;
   lcdsc_div_state_type nxt_st;

   // -------------------------------------------------------------
   // Divider chain
   // -------------------------------------------------------------
   // The output toggles on each half period, so prescale by 8 per edge
   always_comb begin
      nxt_st = st_ff;
      if (reload || !run) begin
         nxt_st = '0;
      end else begin
         nxt_st.pre = st_ff.pre + 4'h1;
         if (st_ff.pre == 4'(LCDSC_PUMP_PRE / 2 - 1)) begin
            nxt_st.pre = '0;
            if (st_ff.cnt == div_val) begin
               nxt_st.cnt = '0;
               nxt_st.out = ~st_ff.out;
            end else begin
               nxt_st.cnt = st_ff.cnt + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pump_clk = st_ff.out;
endmodule // lcdsc_pump_div

// [hw/lcdsc_top.sv]
// LCD driver control and charge pump / regulator supply control
//
// Operation
// - Pump clock is sysclk/16/(divider+1)
// - Regulator off: pump and regulator off
// - Regulator on: pump runs if enabled
// - High supply clears flag; software disables pump
// - Detector off holds flag at zero
// - Flag is one when supply low
// - Flag updates only with detector+regulator on
// - Halt switches pump off automatically
// - Display memory 80H-97H in bank one
// - Other banks route to general memory
// - Display memory only via second pointer
// - Driver scans memory; one lights segment
// - Sleep always blanks the display
// - Type bit picks waveform A or B
// - Bias bit picks third or quarter
// - Resistor field picks bias resistance
// - CMOS pin outputs its memory bit
// - LCD timing from sub clock / 8
// - Display disabled stops segment drive and blanks scan data; CMOS pins keep output
`timescale 1ns/1ns
module lcdsc_top
   import lcdsc_pkg::*;
#(
   parameter int NSEG_IO = 8
) (
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire lcdsc_bus_type bus,
   output logic [7:0] rdata,
   // Core data memory port
   input wire lcdsc_mem_type mem,
   output logic [7:0] mem_rdata,
   output logic gp_mem_sel,
   // Operating state and asynchronous pins
   input wire lcdsc_mode_type mode,
   input wire logic halt,
   input wire logic sub_clk_pin,
   input wire logic vdd_low_pin,
   // Supply control and status
   output logic pump_on,
   output logic regulator_on,
   output logic regulator_out_oe,
   output logic pump_clk,
   output logic detector_on,
   output logic detector_event,
   // Display driver
   output logic display_drive,
   output logic lcd_tick,
   output lcdsc_cfg_type lcd_cfg,
   output logic [7:0] scan_data,
   output logic [4:0] scan_addr,
   output logic [NSEG_IO-1:0] seg_io_out,
   output logic [NSEG_IO-1:0] seg_io_oe
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] pump_ctrl;
      logic [7:0] det_ctrl;
      logic [7:0] disp_ctrl;
      logic [7:0] seg_func;
      logic [2:0] bank;
      logic [7:0] rdata;
      logic [7:0] mrdata;
      logic gp_sel;
      logic [2:0] sub_sync;
      logic [2:0] low_sync;
      logic sub_lvl;
      logic low_lvl;
      logic [2:0] sub_div;
      logic tick;
      logic flag_d;
      logic evt;
      logic [4:0] scan;
      logic [7:0] scan_q;
      logic [NSEG_IO-1:0] io_q;
      logic pump_on;
      logic reg_on;
      logic reg_oe;
      logic det_on;
      logic drive;
      lcdsc_cfg_type cfg;
   } lcdsc_state_type;
   lcdsc_state_type st_ff;
   lcdsc_state_type nxt_st;
   logic [7:0] dmem [LCDSC_DMEM_WORDS];
   logic dmem_wr;
   logic [4:0] dmem_idx;
   logic div_reload;
   logic pump_clk_raw;

   // Display window hit: bank one, 80H-97H, indirect only
   function automatic logic lcdsc_disp_hit(input logic [2:0] bank, input logic [7:0] a,
                                           input logic ind);
      lcdsc_disp_hit = (bank == LCDSC_BANK_DISP) && (a >= LCDSC_DMEM_LO) &&
                       (a <= LCDSC_DMEM_HI) && ind;
   endfunction

   // Duty decode: codes 1 and 3 both give eight commons
   function automatic lcdsc_cfg_type lcdsc_decode(input logic [7:0] c);
      lcdsc_cfg_type r;
      r.wave_b = c[LCDSC_POS_TYPE];
      r.bias_quarter = c[LCDSC_POS_BIAS];
      r.rsel = c[LCDSC_POS_RSEL_LO +: 2];
      unique case (c[LCDSC_POS_DUTY_LO +: 2])
         2'h0: begin
            r.commons = 4'h4;
            r.segments = 5'h18;
         end
         2'h2: begin
            r.commons = 4'h6;
            r.segments = 5'h16;
         end
         2'h1, 2'h3: begin
            r.commons = 4'h8;
            r.segments = 5'h14;
         end
      endcase
      return r;
   endfunction

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      logic reg_en;
      logic disp_ok;
      logic flag;
      reg_en = 1'b0;
      disp_ok = 1'b0;
      flag = 1'b0;
      nxt_st = st_ff;
      nxt_st.rdata = '0;
      // Register writes; masks keep unimplemented bits at zero
      if (bus.wr) begin
         unique case (bus.addr)
            LCDSC_OFS_PUMP_CTRL: nxt_st.pump_ctrl = bus.wdata & LCDSC_MASK_PUMP;
            LCDSC_OFS_DET_CTRL: nxt_st.det_ctrl = bus.wdata & LCDSC_MASK_DET;
            LCDSC_OFS_DISP_CTRL: nxt_st.disp_ctrl = bus.wdata & LCDSC_MASK_DISP;
            LCDSC_OFS_SEG_FUNC: nxt_st.seg_func = bus.wdata;
            LCDSC_OFS_BANK_SEL: nxt_st.bank = bus.wdata[2:0];
            default: ;
         endcase
      end

      // Register reads, data one cycle later; unmapped reads zero
      if (bus.rd) begin
         unique case (bus.addr)
            LCDSC_OFS_PUMP_CTRL: nxt_st.rdata = st_ff.pump_ctrl;
            LCDSC_OFS_DET_CTRL: nxt_st.rdata = st_ff.det_ctrl;
            LCDSC_OFS_DISP_CTRL: nxt_st.rdata = st_ff.disp_ctrl;
            LCDSC_OFS_SEG_FUNC: nxt_st.rdata = st_ff.seg_func;
            LCDSC_OFS_BANK_SEL: nxt_st.rdata = {5'h00, st_ff.bank};
            LCDSC_OFS_STATUS: nxt_st.rdata = {4'h0, st_ff.det_on, st_ff.reg_on,
                                              st_ff.pump_on, st_ff.drive};
            default: nxt_st.rdata = '0;
         endcase
      end

      // Core memory port: display window or general memory
      nxt_st.gp_sel = (mem.wr || mem.rd) &&
                      !lcdsc_disp_hit(st_ff.bank, mem.addr, mem.indirect);
      nxt_st.mrdata = '0;
      if (mem.rd && lcdsc_disp_hit(st_ff.bank, mem.addr, mem.indirect)) begin
         nxt_st.mrdata = dmem[5'(mem.addr - LCDSC_DMEM_LO)];
      end

      // Pin inputs: three flops, change counts when last two agree
      nxt_st.sub_sync = {st_ff.sub_sync[1:0], sub_clk_pin};
      nxt_st.low_sync = {st_ff.low_sync[1:0], vdd_low_pin};
      if (st_ff.sub_sync[2] == st_ff.sub_sync[1]) begin
         nxt_st.sub_lvl = st_ff.sub_sync[2];
      end
      if (st_ff.low_sync[2] == st_ff.low_sync[1]) begin
         nxt_st.low_lvl = st_ff.low_sync[2];
      end

      // LCD tick every eighth sub clock rising edge
      nxt_st.tick = 1'b0;
      if (nxt_st.sub_lvl && !st_ff.sub_lvl) begin
         nxt_st.sub_div = st_ff.sub_div + 3'h1;
         nxt_st.tick = (st_ff.sub_div == 3'(LCDSC_LCD_PRE - 1));
      end

      // Supply control
      reg_en = st_ff.pump_ctrl[LCDSC_POS_REG_EN];
      nxt_st.reg_on = reg_en;
      nxt_st.pump_on = reg_en && st_ff.pump_ctrl[LCDSC_POS_PUMP_EN] && !halt;
      // Off with pump bit clear leaves the output floating
      nxt_st.reg_oe = reg_en || st_ff.pump_ctrl[LCDSC_POS_PUMP_EN];

      // Detector: held at zero when off, frozen unless regulator on
      nxt_st.det_on = st_ff.det_ctrl[LCDSC_POS_DET_EN] && reg_en;
      flag = st_ff.det_ctrl[LCDSC_POS_DET_FLAG];
      if (!st_ff.det_ctrl[LCDSC_POS_DET_EN]) begin
         flag = 1'b0;
      end else if (reg_en) begin
         flag = st_ff.low_lvl;
      end
      nxt_st.det_ctrl[LCDSC_POS_DET_FLAG] = flag;

      // High supply event when the flag falls while detecting
      nxt_st.flag_d = flag;
      nxt_st.evt = st_ff.flag_d && !flag && st_ff.det_ctrl[LCDSC_POS_DET_EN] && reg_en;

      // Display enable is ignored in sleep
      disp_ok = st_ff.disp_ctrl[LCDSC_POS_DISP_EN] && (mode != LCDSC_MODE_SLEEP);
      nxt_st.drive = disp_ok;
      nxt_st.cfg = lcdsc_decode(st_ff.disp_ctrl);

      // Scan display memory continuously on LCD ticks
      if (st_ff.tick) begin
         nxt_st.scan = (st_ff.scan == 5'(LCDSC_DMEM_WORDS - 1)) ? 5'h00 : st_ff.scan + 5'h01;
      end
      // Word is read at the new address so data and address pair up
      nxt_st.scan_q = disp_ok ? dmem[nxt_st.scan] : 8'h00;

      // Shared pins in CMOS mode mirror first memory word bits
      nxt_st.io_q = dmem[0][NSEG_IO-1:0] & st_ff.seg_func[NSEG_IO-1:0];
   end

   // -------------------------------------------------------------
   // Display memory write port
   // -------------------------------------------------------------
   // Contents are undefined after power-on; software must initialise
   assign dmem_wr = mem.wr && lcdsc_disp_hit(st_ff.bank, mem.addr, mem.indirect);
   assign dmem_idx = 5'(mem.addr - LCDSC_DMEM_LO);
   always_ff @(posedge clk) begin
      if (dmem_wr) begin
         dmem[dmem_idx] <= mem.wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.pump_ctrl <= LCDSC_RST_PUMP;
         st_ff.det_ctrl <= LCDSC_RST_DET;
         st_ff.disp_ctrl <= LCDSC_RST_DISP;
         st_ff.seg_func <= LCDSC_RST_SEG;
         st_ff.bank <= LCDSC_RST_BANK;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -------------------------------------------------------------
   // Pump clock divider
   // -------------------------------------------------------------
   assign div_reload = bus.wr && (bus.addr == LCDSC_OFS_PUMP_CTRL);
   lcdsc_pump_div #(.DIV_W(5)) u_div (
      .clk(clk),
      .rst(rst),
      .div_val(st_ff.pump_ctrl[LCDSC_POS_DIV_LO +: 5]),
      .reload(div_reload),
      .run(st_ff.pump_on),
      .pump_clk(pump_clk_raw)
   );
   logic pclk_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pclk_ff <= 1'b0;
      end else begin
         pclk_ff <= pump_clk_raw;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign rdata = st_ff.rdata;
   assign mem_rdata = st_ff.mrdata;
   assign gp_mem_sel = st_ff.gp_sel;
   assign pump_on = st_ff.pump_on;
   assign regulator_on = st_ff.reg_on;
   assign regulator_out_oe = st_ff.reg_oe;
   assign pump_clk = pclk_ff;
   assign detector_on = st_ff.det_on;
   assign detector_event = st_ff.evt;
   assign display_drive = st_ff.drive;
   assign lcd_tick = st_ff.tick;
   assign lcd_cfg = st_ff.cfg;
   assign scan_data = st_ff.scan_q;
   assign scan_addr = st_ff.scan;
   assign seg_io_out = st_ff.io_q;
   assign seg_io_oe = st_ff.seg_func[NSEG_IO-1:0];

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Supply control
   a_pump_off_reg: assert property (!st_ff.pump_ctrl[0] |=> !pump_on)
      else $error("pump on with regulator off");

   a_pump_halt: assert property (halt |=> !pump_on)
      else $error("pump on during halt");

   a_pump_run: assert property (!halt && st_ff.pump_ctrl[1:0] == 2'h3 |=> pump_on)
      else $error("pump not on");

   a_det_power: assert property (!regulator_on |-> !detector_on)
      else $error("detector on with regulator off");

   // Detector
   a_det_zero: assert property (!st_ff.det_ctrl[6] |=> !st_ff.det_ctrl[1])
      else $error("flag set with detector off");

   a_flag_hold: assert property (st_ff.det_ctrl[6] && !st_ff.pump_ctrl[0] |=>
                                 $stable(st_ff.det_ctrl[1]))
      else $error("flag moved with regulator off");

   a_event_pulse: assert property (detector_event |=> !detector_event)
      else $error("event longer than one cycle");

   // Display
   a_sleep_blank: assert property (mode == LCDSC_MODE_SLEEP |=> !display_drive)
      else $error("display driven in sleep");

   a_blank_scan: assert property (!display_drive |-> scan_data == 8'h00 || $past(st_ff.drive))
      else $error("drive while disabled");

   // Registers and memory
   a_no_direct: assert property (mem.wr && !mem.indirect |-> !dmem_wr)
      else $error("direct write hit display memory");

   a_reserved: assert property (st_ff.pump_ctrl[2] == 1'b0 && st_ff.disp_ctrl[4] == 1'b0)
      else $error("reserved bit set");

   // Main scenarios
   c_pump_runs: cover property (pump_on ##1 halt ##1 !pump_on);
   c_disp_on: cover property (display_drive && lcd_tick);
   c_event: cover property (detector_event);
   c_sleep_off: cover property (display_drive ##1 mode == LCDSC_MODE_SLEEP ##1 !display_drive);
endmodule // lcdsc_top

// [include/lcdsc_pkg.sv]
// Package: register map, field layout, reset values and timing constants for the LCD/supply block
package lcdsc_pkg;
   // ---------------------------------------------------------------
   // Register offsets (plain port, word index)
   // ---------------------------------------------------------------
   localparam logic [7:0] LCDSC_OFS_PUMP_CTRL = 8'h00;
   localparam logic [7:0] LCDSC_OFS_DET_CTRL = 8'h01;
   localparam logic [7:0] LCDSC_OFS_DISP_CTRL = 8'h02;
   localparam logic [7:0] LCDSC_OFS_SEG_FUNC = 8'h03;
   localparam logic [7:0] LCDSC_OFS_BANK_SEL = 8'h04;
   localparam logic [7:0] LCDSC_OFS_STATUS = 8'h05;
   // Display memory window, reached only through the second pointer
   localparam logic [7:0] LCDSC_DMEM_LO = 8'h80;
   localparam logic [7:0] LCDSC_DMEM_HI = 8'h97;
   localparam logic [2:0] LCDSC_BANK_DISP = 3'h1;
   localparam int LCDSC_DMEM_WORDS = 24;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int LCDSC_POS_REG_EN = 0;
   localparam int LCDSC_POS_PUMP_EN = 1;
   localparam int LCDSC_POS_DIV_LO = 3;
   localparam int LCDSC_POS_DET_FLAG = 1;
   localparam int LCDSC_POS_DET_EN = 6;
   localparam int LCDSC_POS_DISP_EN = 0;
   localparam int LCDSC_POS_RSEL_LO = 1;
   localparam int LCDSC_POS_BIAS = 3;
   localparam int LCDSC_POS_DUTY_LO = 5;
   localparam int LCDSC_POS_TYPE = 7;
   // Writable masks; other bits ignore writes and read zero, except the detector flag bit
   localparam logic [7:0] LCDSC_MASK_PUMP = 8'hfb;
   localparam logic [7:0] LCDSC_MASK_DET = 8'h40;
   localparam logic [7:0] LCDSC_MASK_DISP = 8'hef;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] LCDSC_RST_PUMP = 8'h00;
   localparam logic [7:0] LCDSC_RST_DET = 8'h00;
   localparam logic [7:0] LCDSC_RST_DISP = 8'h00;
   localparam logic [7:0] LCDSC_RST_SEG = 8'h00;
   localparam logic [2:0] LCDSC_RST_BANK = 3'h0;
   // ---------------------------------------------------------------
   // Clock division
   // ---------------------------------------------------------------
   localparam int LCDSC_PUMP_PRE = 16;
   localparam int LCDSC_LCD_PRE = 8;
   // Operating modes of the device
   typedef enum logic [1:0] {
      LCDSC_MODE_NORMAL = 2'h0,
      LCDSC_MODE_SLOW = 2'h1,
      LCDSC_MODE_IDLE = 2'h3,
      LCDSC_MODE_SLEEP = 2'h2
   } lcdsc_mode_type;
   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lcdsc_bus_type;
   // Data memory access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic indirect;
   } lcdsc_mem_type;
   // Decoded display settings
   typedef struct packed {
      logic wave_b;
      logic [3:0] commons;
      logic [4:0] segments;
      logic bias_quarter;
      logic [1:0] rsel;
   } lcdsc_cfg_type;
endpackage

// [tb/lcdsc_panel_model.sv]
// Passive segment panel model that records what the display drive presents
`timescale 1ns/1ns
module lcdsc_panel_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic display_drive,
   input wire logic [7:0] scan_data,
   input wire logic [4:0] scan_addr,
   output logic [7:0] lit0_ff,
   output logic blank_ff
);
   // ------------------------------------------------------------
   // Panel image
   // ------------------------------------------------------------
   // The glass has no memory of its own: it only lights what is scanned while driven
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lit0_ff <= 8'h00;
         blank_ff <= 1'b1;
      end else begin
         blank_ff <= !display_drive;
         if (display_drive && scan_addr == 5'h00) begin
            lit0_ff <= scan_data;
         end
      end
   end
endmodule // lcdsc_panel_model

// [tb/tb_top.sv]
// Self-checking bench for the LCD driver and supply control block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb_top
   import lcdsc_pkg::*;
   ;
   // ------------------------------------------------------------
   // Stimulus and observation
   // ------------------------------------------------------------
   logic clk, rst, halt, sub_clk_pin, vdd_low_pin;
   lcdsc_bus_type bus;
   lcdsc_mem_type mem;
   lcdsc_mode_type mode;
   logic [7:0] rdata, mem_rdata, scan_data, seg_io_out, seg_io_oe, lit0;
   logic gp_mem_sel, pump_on, regulator_on, regulator_out_oe, pump_clk, blank;
   logic detector_on, detector_event, display_drive, lcd_tick;
   logic [4:0] scan_addr;
   lcdsc_cfg_type lcd_cfg;
   int mismatches, n_tests, sub_cnt;

   lcdsc_top #(.NSEG_IO(8)) i_lcdsc_top (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .mem(mem), .mem_rdata(mem_rdata), .gp_mem_sel(gp_mem_sel), .mode(mode), .halt(halt),
      .sub_clk_pin(sub_clk_pin), .vdd_low_pin(vdd_low_pin), .pump_on(pump_on),
      .regulator_on(regulator_on), .regulator_out_oe(regulator_out_oe), .pump_clk(pump_clk),
      .detector_on(detector_on), .detector_event(detector_event),
      .display_drive(display_drive), .lcd_tick(lcd_tick), .lcd_cfg(lcd_cfg),
      .scan_data(scan_data), .scan_addr(scan_addr), .seg_io_out(seg_io_out),
      .seg_io_oe(seg_io_oe));

   lcdsc_panel_model i_lcdsc_panel_model (.clk(clk), .rst(rst), .display_drive(display_drive),
      .scan_data(scan_data), .scan_addr(scan_addr), .lit0_ff(lit0), .blank_ff(blank));

   // System clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Sub clock of ten system cycles; slow enough that the synchroniser never misses an edge
   always @(posedge clk) begin
      sub_cnt <= (sub_cnt == 4) ? 0 : sub_cnt + 1;
      if (sub_cnt == 4) begin
         sub_clk_pin <= !sub_clk_pin;
      end
   end

   // ------------------------------------------------------------
   // Bus and helper tasks
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      `CHK(nm, exp, rdata)
   endtask

   task automatic mem_acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                          input logic ind);
      @(posedge clk);
      mem.addr <= a;
      mem.wdata <= d;
      mem.wr <= w;
      mem.rd <= !w;
      mem.indirect <= ind;
      @(posedge clk);
      mem.wr <= 1'b0;
      mem.rd <= 1'b0;
      #1;
   endtask

   // Register outputs lag the register by one cycle; three gives margin
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic rise(output int cyc);
      logic p;
      cyc = 0;
      p = 1'b1;
      while (cyc < 2000 && !(p === 1'b0 && pump_clk === 1'b1)) begin
         p = pump_clk;
         @(posedge clk);
         #1;
         cyc++;
      end
   endtask

   task automatic tick_gap(output int cyc);
      int n;
      n = 0;
      while (lcd_tick !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      cyc = 0;
      do begin
         @(posedge clk);
         #1;
         cyc++;
      end while (lcd_tick !== 1'b1 && cyc < 400);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rd_chk("pump_ctrl", LCDSC_OFS_PUMP_CTRL, LCDSC_RST_PUMP);
      rd_chk("det_ctrl", LCDSC_OFS_DET_CTRL, LCDSC_RST_DET);
      rd_chk("disp_ctrl", LCDSC_OFS_DISP_CTRL, LCDSC_RST_DISP);
      rd_chk("seg_func", LCDSC_OFS_SEG_FUNC, LCDSC_RST_SEG);
      rd_chk("bank_sel", LCDSC_OFS_BANK_SEL, {5'h00, LCDSC_RST_BANK});
      wr_reg(8'h3c, 8'hff);
      rd_chk("unmapped", 8'h3c, 8'h00);
      wr_reg(LCDSC_OFS_PUMP_CTRL, 8'hfe);
      rd_chk("pump_mask", LCDSC_OFS_PUMP_CTRL, 8'hfa);
      wr_reg(LCDSC_OFS_DISP_CTRL, 8'hfe);
      rd_chk("disp_mask", LCDSC_OFS_DISP_CTRL, 8'hee);
      wr_reg(LCDSC_OFS_DET_CTRL, 8'hff);
      rd_chk("det_mask", LCDSC_OFS_DET_CTRL, 8'h40);
      wr_reg(LCDSC_OFS_DET_CTRL, 8'h00);
      wr_reg(LCDSC_OFS_DISP_CTRL, 8'h00);
   endtask

   task automatic t_supply;
      for (int k = 0; k < 4; k++) begin
         // Only digital state follows the regulator here, so no analog settling wait
         wr_reg(LCDSC_OFS_PUMP_CTRL, {6'h00, k[1:0]});
         settle();
         `CHK("regulator_on", k[0], regulator_on)
         `CHK("pump_on", k[0] & k[1], pump_on)
         `CHK("reg_out_oe", k[0] | k[1], regulator_out_oe)
         rd_chk("status", LCDSC_OFS_STATUS, {5'h00, k[0], k[0] & k[1], 1'b0});
      end
      @(posedge clk);
      halt <= 1'b1;
      settle();
      `CHK("halt_pump", 1'b0, pump_on)
      `CHK("halt_clk", 1'b0, pump_clk)
      @(posedge clk);
      halt <= 1'b0;
      settle();
      `CHK("unhalt_pump", 1'b1, pump_on)
   endtask

   task automatic t_pump_clk;
      int divs[3] = '{0, 1, 31};
      int per;
      foreach (divs[i]) begin
         // Dividers 0 and 1 plus the largest field value 31, not tuned to the pump optimum
         wr_reg(LCDSC_OFS_PUMP_CTRL, {divs[i][4:0], 3'h3});
         rise(per);
         rise(per);
         `CHK("pump_period", LCDSC_PUMP_PRE * (divs[i] + 1), per)
      end
   endtask

   task automatic t_detector;
      int n;
      @(posedge clk);
      vdd_low_pin <= 1'b1;
      settle();
      rd_chk("flag_off", LCDSC_OFS_DET_CTRL, 8'h00);
      `CHK("det_on_off", 1'b0, detector_on)
      wr_reg(LCDSC_OFS_DET_CTRL, 8'h40);
      settle();
      settle();
      `CHK("det_on", 1'b1, detector_on)
      rd_chk("flag_low", LCDSC_OFS_DET_CTRL, 8'h42);
      @(posedge clk);
      vdd_low_pin <= 1'b0;
      n = 0;
      while (detector_event !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("det_event", 1'b1, detector_event)
      @(posedge clk);
      #1;
      `CHK("det_pulse", 1'b0, detector_event)
      rd_chk("flag_high", LCDSC_OFS_DET_CTRL, 8'h40);
      wr_reg(LCDSC_OFS_PUMP_CTRL, 8'h01);
      settle();
      `CHK("pump_off", 1'b0, pump_on)
      // With the regulator off the flag must not follow the pin
      wr_reg(LCDSC_OFS_PUMP_CTRL, 8'h00);
      @(posedge clk);
      vdd_low_pin <= 1'b1;
      settle();
      settle();
      rd_chk("flag_frozen", LCDSC_OFS_DET_CTRL, 8'h40);
      `CHK("det_frozen", 1'b0, detector_on)
      wr_reg(LCDSC_OFS_DET_CTRL, 8'h00);
   endtask

   task automatic t_mem;
      wr_reg(LCDSC_OFS_BANK_SEL, {5'h00, LCDSC_BANK_DISP});
      mem_acc(1'b1, LCDSC_DMEM_LO, 8'ha5, 1'b1);
      `CHK("gp_sel_lo", 1'b0, gp_mem_sel)
      mem_acc(1'b1, LCDSC_DMEM_HI, 8'h3c, 1'b1);
      mem_acc(1'b0, LCDSC_DMEM_HI, 8'h00, 1'b1);
      `CHK("dmem_hi", 8'h3c, mem_rdata)
      mem_acc(1'b1, LCDSC_DMEM_LO, 8'hff, 1'b0);
      mem_acc(1'b0, LCDSC_DMEM_LO, 8'h00, 1'b0);
      `CHK("direct_rd", 8'h00, mem_rdata)
      wr_reg(LCDSC_OFS_BANK_SEL, 8'h02);
      mem_acc(1'b1, LCDSC_DMEM_LO, 8'h11, 1'b1);
      `CHK("gp_bank2", 1'b1, gp_mem_sel)
      mem_acc(1'b0, 8'hff, 8'h00, 1'b1);
      `CHK("gp_top", 1'b1, gp_mem_sel)
      wr_reg(LCDSC_OFS_BANK_SEL, {5'h00, LCDSC_BANK_DISP});
      mem_acc(1'b0, LCDSC_DMEM_LO, 8'h00, 1'b1);
      `CHK("dmem_lo", 8'ha5, mem_rdata)
   endtask

   task automatic t_display;
      int com[4] = '{4, 8, 6, 8};
      int seg[4] = '{24, 20, 22, 20};
      lcdsc_mode_type ms[4] = '{LCDSC_MODE_NORMAL, LCDSC_MODE_SLOW, LCDSC_MODE_IDLE,
                                LCDSC_MODE_SLEEP};
      int gap;
      wr_reg(LCDSC_OFS_PUMP_CTRL, 8'h01);
      wr_reg(LCDSC_OFS_SEG_FUNC, 8'h0f);
      settle();
      `CHK("seg_oe", 8'h0f, seg_io_oe)
      `CHK("seg_out", 8'h05, seg_io_out)
      for (int d = 0; d < 4; d++) begin
         wr_reg(LCDSC_OFS_DISP_CTRL, {1'b1, d[1:0], 5'h0f});
         settle();
         `CHK("commons", com[d][3:0], lcd_cfg.commons)
         `CHK("segments", seg[d][4:0], lcd_cfg.segments)
      end
      `CHK("wave_b", 1'b1, lcd_cfg.wave_b)
      `CHK("bias_q", 1'b1, lcd_cfg.bias_quarter)
      `CHK("rsel3", 2'h3, lcd_cfg.rsel)
      wr_reg(LCDSC_OFS_DISP_CTRL, 8'h03);
      settle();
      `CHK("wave_a", 1'b0, lcd_cfg.wave_b)
      `CHK("bias_t", 1'b0, lcd_cfg.bias_quarter)
      `CHK("rsel1", 2'h1, lcd_cfg.rsel)
      foreach (ms[i]) begin
         @(posedge clk);
         mode <= ms[i];
         settle();
         `CHK("drive_mode", (i != 3), display_drive)
      end
      @(posedge clk);
      mode <= LCDSC_MODE_NORMAL;
      tick_gap(gap);
      tick_gap(gap);
      `CHK("tick_gap", LCDSC_LCD_PRE * 10, gap)
      for (int n = 0; n < 5000 && lit0 !== 8'ha5; n++) begin
         @(posedge clk);
         #1;
      end
      `CHK("panel_word0", 8'ha5, lit0)
      wr_reg(LCDSC_OFS_DISP_CTRL, 8'h02);
      settle();
      `CHK("drive_off", 1'b0, display_drive)
      `CHK("scan_blank", 8'h00, scan_data)
      `CHK("panel_blank", 1'b1, blank)
   endtask

   // ------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // The whole sequence needs well under 20000 cycles
   initial begin
      #200000;
      mismatches++;
      finish_test();
   end

   initial begin
      mismatches = 0;
      n_tests = 0;
      sub_cnt = 0;
      rst = 1'b1;
      bus = '0;
      mem = '0;
      mode = LCDSC_MODE_NORMAL;
      halt = 1'b0;
      sub_clk_pin = 1'b0;
      vdd_low_pin = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_supply();
      t_pump_clk();
      t_detector();
      t_mem();
      t_display();
      finish_test();
   end
endmodule // tb_top
